// File: hw/reset_strap_config.v
// reset, strap capture, reset output and system clock range control
// assumes chip_reset_n and straps come from pins; AHB-Lite master on clock
`timescale 1ns/1ps
`include "reset_strap_map.vh"

module reset_strap_config #(
  parameter integer RESET_OUT_CYCLES = (`CLOCK_HZ / 1000) * `RESET_OUT_MS
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // pins
  input wire chip_reset_n,
  input wire [1:0] boot_bank_width_strap,
  input wire reset_out_polarity_strap,
  input wire cpu_clock_source_strap,
  input wire bridge_role_strap,
  input wire factory_test_enable,
  output reg wdt_reset_out,
  // sdram read path
  input wire sdram_read_clock_in,
  input wire [31:0] sdram_data_in,
  output reg [31:0] sdram_read_data,
  // configuration outputs
  output reg [1:0] bank0_width,
  output reg pll_bypass,
  output reg host_bridge_mode,
  output reg test_mode,
  output reg [2:0] sys_clock_sel,
  output reg core_reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [6:0] pin_s1_r;
  reg [6:0] pin_s2_r;
  wire [6:0] pins_raw = {factory_test_enable, bridge_role_strap, cpu_clock_source_strap,
                         reset_out_polarity_strap, boot_bank_width_strap, chip_reset_n};
  always @(posedge clock) begin
    pin_s1_r <= pins_raw;
    pin_s2_r <= pin_s1_r;
  end
  wire chip_reset_s = ~pin_s2_r[0];

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  reg [1:0] width_r;
  reg pol_r;
  reg cpuclk_r;
  reg bridge_r;
  reg test_r;
  reg chip_reset_d_r;
  reg strap_valid_r;
  reg wdt_cause_r;
  always @(posedge clock) begin
    chip_reset_d_r <= chip_reset_s;
    if (chip_reset_s) begin
      width_r <= pin_s2_r[2:1];
      pol_r <= pin_s2_r[3];
      cpuclk_r <= pin_s2_r[4];
      bridge_r <= pin_s2_r[5];
      test_r <= pin_s2_r[6];
    end
    // values frozen from release onward
    if (!rst_b) begin
      strap_valid_r <= 1'b0;
    end else if (chip_reset_d_r && !chip_reset_s) begin
      strap_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // registers and watchdog
  // ----------------------------------------
  reg [2:0] clk_sel_r;
  reg wdt_en_r;
  reg [31:0] wdt_load_r;
  reg [31:0] wdt_cnt_r;
  reg wdt_fire_r;
  reg ap_valid_r;
  reg ap_write_r;
  reg [7:0] ap_addr_r;
  wire ap_take = hsel & htrans[1] & hready;
  wire wr_now = ap_valid_r & ap_write_r;
  wire wdt_restart = wr_now & (ap_addr_r == `WDT_LOAD_OFFSET);
  wire sys_reset = chip_reset_s | wdt_fire_r;

  always @(posedge clock) begin
    if (!rst_b || chip_reset_s) begin
      clk_sel_r <= `CLKCTL_RESET;
      wdt_en_r <= 1'b0;
      wdt_load_r <= `WDT_LOAD_RESET;
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r <= haddr;
      if (wdt_fire_r) begin
        clk_sel_r <= `CLKCTL_RESET;
        wdt_en_r <= 1'b0;
      end else if (wr_now) begin
        case (ap_addr_r)
          `CLKCTL_OFFSET: begin
            if (hwdata[`CLKCTL_SEL_MSB:0] <= `CLK_SEL_MAX) begin
              clk_sel_r <= hwdata[`CLKCTL_SEL_MSB:0];
            end
          end
          `WDT_CTRL_OFFSET: begin
            wdt_en_r <= hwdata[`WDT_EN_BIT];
          end
          `WDT_LOAD_OFFSET: begin
            wdt_load_r <= hwdata;
          end
          default: begin
            wdt_en_r <= wdt_en_r;
          end
        endcase
      end
    end
  end

  // watchdog counts down only once enabled
  always @(posedge clock) begin
    if (!rst_b || chip_reset_s) begin
      wdt_cnt_r <= `WDT_LOAD_RESET;
      wdt_fire_r <= 1'b0;
      wdt_cause_r <= 1'b0;
    end else begin
      wdt_fire_r <= 1'b0;
      if (!wdt_en_r || wdt_restart) begin
        wdt_cnt_r <= wdt_restart ? hwdata : wdt_load_r;
      end else if (wdt_cnt_r == 32'h0000_0000) begin
        wdt_fire_r <= 1'b1;
        wdt_cause_r <= 1'b1;
        wdt_cnt_r <= wdt_load_r;
      end else begin
        wdt_cnt_r <= wdt_cnt_r - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // reset output stretch
  // ----------------------------------------
  reg [31:0] stretch_r;
  wire stretch_busy = (stretch_r != 32'h0000_0000);
  always @(posedge clock) begin
    if (!rst_b) begin
      stretch_r <= RESET_OUT_CYCLES[31:0];
    end else if (sys_reset) begin
      stretch_r <= RESET_OUT_CYCLES[31:0];
    end else if (stretch_busy) begin
      stretch_r <= stretch_r - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire out_asserted = sys_reset | stretch_busy;
  always @(posedge clock) begin
    if (!rst_b) begin
      // polarity unknown until straps seen: idle low
      wdt_reset_out <= 1'b0;
      core_reset_n <= 1'b0;
      bank0_width <= 2'h3;
      pll_bypass <= 1'b0;
      host_bridge_mode <= 1'b0;
      test_mode <= 1'b0;
      sys_clock_sel <= 3'h4;
    end else begin
      wdt_reset_out <= out_asserted ^ pol_r;
      core_reset_n <= ~sys_reset & strap_valid_r;
      if (strap_valid_r) begin
        bank0_width <= width_r;
        pll_bypass <= cpuclk_r;
        host_bridge_mode <= bridge_r;
        test_mode <= test_r;
      end
      sys_clock_sel <= clk_sel_r;
    end
  end

  // sdram read data on the returned clock
  always @(posedge sdram_read_clock_in) begin
    sdram_read_data <= sdram_data_in;
  end

  // ----------------------------------------
  // ahb read data
  // ----------------------------------------
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (haddr)
      `CLKCTL_OFFSET: rd_nxt = {29'h0, clk_sel_r};
      `STRAP_STATUS_OFFSET: rd_nxt = {25'h0, wdt_cause_r, test_r, bridge_r, cpuclk_r, pol_r, width_r};
      `WDT_CTRL_OFFSET: rd_nxt = {31'h0, wdt_en_r};
      `WDT_LOAD_OFFSET: rd_nxt = wdt_load_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always @(posedge clock) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

endmodule

// File: hw/reset_strap_map.vh
// reset, strap and clock configuration constants
// assumes inclusion by the reset/strap configuration block only
`ifndef RESET_STRAP_MAP_VH
`define RESET_STRAP_MAP_VH
// register byte offsets
`define CLKCTL_OFFSET 8'h04
`define STRAP_STATUS_OFFSET 8'h08
`define WDT_CTRL_OFFSET 8'h0C
`define WDT_LOAD_OFFSET 8'h10
// clock control fields: system clock select in [2:0]
`define CLKCTL_SEL_MSB 2
`define CLKCTL_RESET 3'h4
// system clock settings, index 0 = 25 MHz .. 4 = 125 MHz
`define CLK_SEL_MAX 3'h4
// strap status fields
`define ST_WIDTH_LSB 0
`define ST_POL_BIT 2
`define ST_CPUCLK_BIT 3
`define ST_BRIDGE_BIT 4
`define ST_TEST_BIT 5
`define ST_WDT_CAUSE_BIT 6
// watchdog control fields
`define WDT_EN_BIT 0
`define WDT_LOAD_RESET 32'h0100_0000
// timing
`define CLOCK_HZ 40000000
`define RESET_OUT_MS 200
`define CHIP_RESET_MIN_CYCLES 256
`endif

// File: verification/board_reset_model.sv
// board side: reset source and strap pulls
// assumes one start pulse per reset, cfg = width, pol, cpu, bridge, test
`timescale 1ns/1ps
module board_reset_model (
  // clock and request
  input wire clock,
  input wire start,
  input wire [5:0] cfg,
  // pins
  output reg chip_reset_n = 1'b1,
  output reg [1:0] boot_bank_width_strap = 2'h1,
  output reg reset_out_polarity_strap = 1'b0,
  output reg cpu_clock_source_strap = 1'b0,
  output reg bridge_role_strap = 1'b0,
  output reg factory_test_enable = 1'b0
);
  integer hold = 0;
  always @(posedge clock) begin
    if (start) begin
      chip_reset_n <= 1'b0;
      hold <= 300;
      {boot_bank_width_strap, reset_out_polarity_strap} <= cfg[5:3];
      {cpu_clock_source_strap, bridge_role_strap} <= cfg[2:1];
      factory_test_enable <= cfg[0];
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else if (hold == 1) begin
      hold <= 0;
      chip_reset_n <= 1'b1;
    end else begin
      // released pins carry other traffic
      {boot_bank_width_strap, reset_out_polarity_strap} <= ~{boot_bank_width_strap, reset_out_polarity_strap};
      {cpu_clock_source_strap, bridge_role_strap} <= ~{cpu_clock_source_strap, bridge_role_strap};
    end
  end
endmodule

// File: verification/reset_strap_config_sva.sv
// checker for strap capture, reset output and clock range
// assumes binding onto the block, straps held steady during reset
`timescale 1ns/1ps
module reset_strap_config_sva (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // pins
  input wire chip_reset_n,
  input wire [1:0] boot_bank_width_strap,
  input wire reset_out_polarity_strap,
  input wire cpu_clock_source_strap,
  input wire bridge_role_strap,
  input wire factory_test_enable,
  input wire wdt_reset_out,
  // configuration
  input wire [1:0] bank0_width,
  input wire pll_bypass,
  input wire host_bridge_mode,
  input wire test_mode,
  input wire [2:0] sys_clock_sel,
  input wire core_reset_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_bank_width: assert property ($rose(core_reset_n) && !$past(chip_reset_n, 5) |->
    bank0_width == $past(boot_bank_width_strap, 5)) else $error("bank width");
  a_pll_bypass: assert property ($rose(core_reset_n) && !$past(chip_reset_n, 5) |->
    pll_bypass == $past(cpu_clock_source_strap, 5)) else $error("pll bypass");
  a_bridge_role: assert property ($rose(core_reset_n) && !$past(chip_reset_n, 5) |->
    host_bridge_mode == $past(bridge_role_strap, 5)) else $error("bridge role");
  a_test_mode: assert property ($rose(core_reset_n) && !$past(chip_reset_n, 5) |->
    test_mode == $past(factory_test_enable, 5)) else $error("test mode");
  a_out_level: assert property ((!chip_reset_n && $stable(reset_out_polarity_strap))[*8] |->
    wdt_reset_out == !reset_out_polarity_strap) else $error("reset out level");
  a_out_hold: assert property ($rose(chip_reset_n) |-> $stable(wdt_reset_out)[*8])
    else $error("reset out short");
  a_wdt_pulse: assert property ($fell(core_reset_n) && chip_reset_n |=> core_reset_n)
    else $error("watchdog pulse");
  a_clock_range: assert property (sys_clock_sel <= 3'h4) else $error("clock range");
  c_wdt: cover property ($fell(core_reset_n) && chip_reset_n);
  c_release: cover property ($rose(chip_reset_n));
  c_slow: cover property (sys_clock_sel == 3'h0);
endmodule

// File: verification/reset_strap_config_test.sv
// bench: board model, bus master and expected values
// assumes the checker and board model compile first
`timescale 1ns/1ps
module reset_strap_config_test;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg start = 1'b0;
  reg hwrite = 1'b0;
  reg [5:0] cfg = 6'h10;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] sdram_data_in = 32'h0;
  reg [31:0] r;
  wire chip_reset_n, reset_out_polarity_strap, cpu_clock_source_strap, bridge_role_strap, factory_test_enable;
  wire wdt_reset_out, pll_bypass, host_bridge_mode, test_mode, core_reset_n, hreadyout, hresp;
  wire [1:0] boot_bank_width_strap, bank0_width;
  wire [2:0] sys_clock_sel;
  wire [31:0] sdram_read_data, hrdata;
  wire hsel = 1'b1;
  wire [2:0] hsize = 3'h2;
  wire hready = hreadyout;
  wire sdram_read_clock_in = clock;
  integer bad_count = 0, num_checks = 0, seed = 32'hB51B, i, k, clk_exp;
  always #12.5 clock = ~clock;
  board_reset_model brd_u (.*);
  reset_strap_config #(.RESET_OUT_CYCLES(20)) dut_u (.*);
  task chk(input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clock);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      r = hrdata;
      chk({hreadyout, hresp}, 32'h2);
    end
  endtask
  task wait_core(input v);
    begin
      k = 0;
      while (core_reset_n !== v && k < 400) begin
        @(posedge clock);
        #1;
        k = k + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("checks=%0d errors=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      cfg <= {2'(i % 3 + 1), i[0], i[1], ~i[0], i == 3};
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (10) @(posedge clock);
      #1 chk(wdt_reset_out, !cfg[3]);
      wait_core(1'b1);
      chk(core_reset_n, 1'b1);
      chk({bank0_width, pll_bypass, host_bridge_mode, test_mode}, {cfg[5:4], cfg[2:0]});
      repeat (25) @(posedge clock);
      #1 chk(wdt_reset_out, cfg[3]);
      bus(8'h08, 1'b0, 32'h0);
      chk(r, {cfg[0], cfg[1], cfg[2], cfg[3], cfg[5:4]});
      bus(8'h04, 1'b0, 32'h0);
      chk(r, 32'h4);
      clk_exp = 4;
      repeat (3) begin
        k = $random(seed) & 7;
        bus(8'h04, 1'b1, k);
        if (k <= 4) clk_exp = k;
        bus(8'h04, 1'b0, 32'h0);
        chk(r, clk_exp);
        chk(sys_clock_sel, clk_exp);
      end
      bus(8'h20, 1'b0, 32'h0);
      chk(r, 32'h0);
      bus(8'h10, 1'b1, 32'h8);
      bus(8'h0C, 1'b1, 32'h1);
      wait_core(1'b0);
      chk(core_reset_n, 1'b0);
      repeat (2) @(posedge clock);
      #1 chk(wdt_reset_out, !cfg[3]);
      bus(8'h08, 1'b0, 32'h0);
      chk(r[6], 1'b1);
    end
    sdram_data_in <= $random(seed);
    repeat (2) @(posedge clock);
    #1 chk(sdram_read_data, sdram_data_in);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count = bad_count + 1;
    summarize;
  end
endmodule
bind reset_strap_config reset_strap_config_sva chk_u (.*);
